// ---- shared/scan_pkg.sv ----
package scan_pkg;

  // ----------------------------------------
  // Geometry and timing
  // ----------------------------------------
  localparam int COLUMNS = 8;
  localparam int ROWS = 8;
  // Nanoseconds a column is held before the rows are sampled
  localparam int SETTLE_NS = 40;
  localparam int CLK_NS = 4;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // Start pattern: most significant column line
  localparam logic [7:0] COL_START = 8'h80;
  localparam logic [7:0] COL_IDLE = 8'h00;
  localparam logic [2:0] ADDR_START = 3'h7;
  localparam logic [63:0] MAP_RESET = 64'h0000000000000000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {IDLE, SETTLE, CAPTURE, DONE} phase_type;

  // Column drive group, all three variants
  typedef struct packed {
    logic [7:0] onehot;
    logic [7:0] onehot_b;
    logic [2:0] addr;
  } col_drive_type;

  // Map read request and answer
  typedef struct packed {
    logic [5:0] index;
  } bit_req_type;

  typedef struct packed {
    logic cur;
    logic prev;
    logic rise;
    logic fall;
  } bit_ans_type;

endpackage

// ---- src/row_sync.sv ----
`timescale 1ns/1ps
module row_sync
  import scan_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type state_r;
  sync_state_type state_nxt;

  // First stage feeds only the second
  always_comb begin
    state_nxt = state_r;
    state_nxt.stage1 = pin_in;
    state_nxt.stage2 = state_r.stage1;
  end

  // Register both stages
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pin_sync = state_r.stage2;

endmodule // row_sync

// ---- src/bit_map_mem.sv ----
`timescale 1ns/1ps
module bit_map_mem
  import scan_pkg::*;
#(
  parameter int COLS = 8,
  parameter int ROWW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Column write
  input wire logic wr_en,
  input wire logic [2:0] wr_col,
  input wire logic [ROWW-1:0] wr_data,
  // Bit read
  input wire logic [5:0] rd_index,
  output logic rd_cur,
  output logic rd_prev,
  // Whole maps
  output logic [COLS*ROWW-1:0] cur_map,
  output logic [COLS*ROWW-1:0] prev_map
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [COLS*ROWW-1:0] cur;
    logic [COLS*ROWW-1:0] prev;
    logic rcur;
    logic rprev;
  } mem_state_type;

  mem_state_type state_r;
  mem_state_type state_nxt;

  // Write moves the old byte into prev and stores the new one, read registers one bit of each map
  always_comb begin
    state_nxt = state_r;
    if (wr_en) begin
      state_nxt.prev[wr_col*ROWW +: ROWW] = state_r.cur[wr_col*ROWW +: ROWW];
      state_nxt.cur[wr_col*ROWW +: ROWW] = wr_data;
    end
    state_nxt.rcur = state_r.cur[rd_index];
    state_nxt.rprev = state_r.prev[rd_index];
  end

  // Register the maps
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rd_cur = state_r.rcur;
  assign rd_prev = state_r.rprev;
  assign cur_map = state_r.cur;
  assign prev_map = state_r.prev;

endmodule // bit_map_mem

// ---- src/sensor_matrix_scanner.sv ----
`timescale 1ns/1ps
module sensor_matrix_scanner
  import scan_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Scan control
  input wire logic scan_start,
  output logic scan_busy,
  output logic scan_done,
  // Column drive port, three variants
  output col_drive_type column_drive_port,
  // Row return port and its release
  input wire logic [7:0] row_return_port,
  output logic row_port_claimed,
  // Bit-addressed map access
  input bit_req_type bit_req,
  output bit_ans_type bit_ans,
  // Whole maps and change flags
  output logic [63:0] current_map,
  output logic [63:0] previous_map,
  output logic [63:0] changed_map
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    phase_type phase;
    logic [7:0] onehot;
    logic [2:0] addr;
    logic [7:0] wait_cnt;
    logic done;
  } scan_state_type;

  scan_state_type state_r;
  scan_state_type state_nxt;

  logic [7:0] rows_sync;  // Row lines after two flops
  logic wr_en;            // Column capture strobe
  logic rd_cur;           // Current bit read
  logic rd_prev;          // Previous bit read

  // ----------------------------------------
  // Row input synchroniser
  // ----------------------------------------
  row_sync #(
    .WIDTH(ROWS)
  ) u_row_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(row_return_port),
    .pin_sync(rows_sync)
  );

  // ----------------------------------------
  // Bit maps
  // ----------------------------------------
  // two maps kept
  bit_map_mem #(
    .COLS(COLUMNS),
    .ROWW(ROWS)
  ) u_maps (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(wr_en),
    .wr_col(state_r.addr),
    .wr_data(rows_sync),
    .rd_index(bit_req.index),
    .rd_cur(rd_cur),
    .rd_prev(rd_prev),
    .cur_map(current_map),
    .prev_map(previous_map)
  );

  // Capture happens in the capture phase only
  // capture enabled column
  assign wr_en = (state_r.phase == CAPTURE);

  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.done = 1'b0;
    case (state_r.phase)
      // Wait for a start request
      IDLE: begin
        if (scan_start) begin
          state_nxt.onehot = COL_START;
          state_nxt.addr = ADDR_START;
          state_nxt.wait_cnt = 8'(SETTLE_CYCLES);
          state_nxt.phase = SETTLE;
        end
      end
      // Let the column and the synchroniser settle
      SETTLE: begin
        if (state_r.wait_cnt == 8'h00) begin
          state_nxt.phase = CAPTURE;
        end else begin
          state_nxt.wait_cnt = state_r.wait_cnt - 8'h01;
        end
      end
      // One cycle write, then step
      CAPTURE: begin
        state_nxt.onehot = {state_r.onehot[0], state_r.onehot[7:1]};
        state_nxt.addr = state_r.addr - 3'h1;
        state_nxt.wait_cnt = 8'(SETTLE_CYCLES);
        if (state_r.onehot[0]) begin
          state_nxt.onehot = COL_IDLE;
          state_nxt.phase = DONE;
        end else begin
          state_nxt.phase = SETTLE;
        end
      end
      // Pass complete, release lines
      DONE: begin
        state_nxt.onehot = COL_IDLE;
        state_nxt.done = 1'b1;
        state_nxt.phase = IDLE;
      end
      default: begin
        state_nxt.phase = IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic active;  // Columns being driven
  assign active = (state_r.phase == SETTLE) || (state_r.phase == CAPTURE);

  // at most one bit set
  // Pins straight from the register, no decode glitch
  assign column_drive_port.onehot = state_r.onehot;
  assign column_drive_port.onehot_b = ~state_r.onehot;
  assign column_drive_port.addr = state_r.addr;

  assign row_port_claimed = active;
  assign scan_busy = state_r.phase != IDLE;
  assign scan_done = state_r.done;

  assign bit_ans.cur = rd_cur;
  assign bit_ans.prev = rd_prev;
  assign bit_ans.rise = rd_cur & ~rd_prev;
  assign bit_ans.fall = ~rd_cur & rd_prev;
  assign changed_map = current_map ^ previous_map;

endmodule // sensor_matrix_scanner

// ---- bench/sensor_matrix_model.sv ----
`timescale 1ns/1ps
module sensor_matrix_model (
  // Column enables in
  input wire logic [7:0] col_en,
  // Contact states, byte c is column c
  input wire logic [63:0] closed,
  // Other traffic on the shared port between scans
  input wire logic [7:0] idle_bus,
  // Row returns out
  output logic [7:0] rows
);
  always_comb begin
    rows = 8'h00;
    for (int c = 0; c < 8; c++) begin
      if (col_en[c]) begin
        rows = rows | closed[8*c +: 8];
      end
    end
    // port lent out while no column is enabled
    if (col_en == 8'h00) begin
      rows = idle_bus;
    end
  end
endmodule // sensor_matrix_model

// ---- bench/scanner_sva.sv ----
`timescale 1ns/1ps
module scanner_sva
  import scan_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Scan control
  input wire logic scan_start,
  input wire logic scan_busy,
  input wire logic scan_done,
  // Matrix side
  input col_drive_type column_drive_port,
  input wire logic [7:0] row_return_port,
  input wire logic row_port_claimed,
  // Map side
  input bit_req_type bit_req,
  input bit_ans_type bit_ans,
  input wire logic [63:0] current_map,
  input wire logic [63:0] previous_map,
  input wire logic [63:0] changed_map
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Active-high column lines
  wire logic [7:0] oh = column_drive_port.onehot;
  a_one_column: assert property (
    row_port_claimed |-> $onehot(oh)) else $error("column drive not one-hot");
  a_idle_drive: assert property (
    !row_port_claimed |-> oh == 8'h00) else $error("columns driven while released");
  a_inverse_lines: assert property (
    column_drive_port.onehot_b == ~oh) else $error("low-active lines wrong");
  a_addr_match: assert property (
    row_port_claimed |-> oh == (8'h01 << column_drive_port.addr)) else $error("address mismatch");
  a_start_top: assert property (
    !scan_busy && scan_start |=> oh == 8'h80 && scan_busy) else $error("bad scan start");
  a_rotate_right: assert property (
    $past(oh) != 8'h00 && oh != 8'h00 && $changed(oh) |-> oh == ($past(oh) >> 1))
    else $error("column step wrong");
  a_column_hold: assert property (
    $changed(oh) && oh != 8'h00 |=> $stable(oh) [*8]) else $error("column not held");
  a_done_pulse: assert property (
    scan_done |-> !scan_busy ##1 !scan_done) else $error("done pulse wrong");
  a_map_xor: assert property (
    changed_map == (current_map ^ previous_map)) else $error("change map wrong");
  a_bit_read: assert property (
    $stable(current_map) && $stable(previous_map) && $stable(bit_req) |->
    bit_ans.cur == current_map[bit_req.index] && bit_ans.prev == previous_map[bit_req.index])
    else $error("bit read wrong");
  a_edge_flags: assert property (
    bit_ans.rise == (bit_ans.cur & !bit_ans.prev) && bit_ans.fall == (!bit_ans.cur & bit_ans.prev))
    else $error("edge flags wrong");
endmodule // scanner_sva
bind sensor_matrix_scanner scanner_sva scanner_sva_inst (.*);

// ---- bench/test_sensor_matrix_scanner.sv ----
`timescale 1ns/1ps
module test_sensor_matrix_scanner;
  import scan_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic scan_start = 1'b0;
  bit_req_type bit_req = '0;
  logic [63:0] closed = 64'h0;
  logic [63:0] last_pat = 64'h0;
  logic [7:0] idle_bus = 8'h00;
  col_drive_type col;
  logic [7:0] rows;
  logic scan_busy, scan_done, claimed;
  bit_ans_type bit_ans;
  logic [63:0] cur_map, prev_map, chg_map;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2 mclk = ~mclk;
  sensor_matrix_scanner sensor_matrix_scanner_inst (.mclk(mclk), .rst_b(rst_b),
    .scan_start(scan_start), .scan_busy(scan_busy), .scan_done(scan_done),
    .column_drive_port(col), .row_return_port(rows), .row_port_claimed(claimed),
    .bit_req(bit_req), .bit_ans(bit_ans), .current_map(cur_map),
    .previous_map(prev_map), .changed_map(chg_map));
  sensor_matrix_model sensor_matrix_model_inst (.col_en(col.onehot), .closed(closed),
    .idle_bus(idle_bus), .rows(rows));
  // Compare and count
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // One pass; poke raises start while busy
  task automatic run_scan(input logic [63:0] pat, input logic poke);
    logic [7:0] want;
    logic [7:0] last;
    logic [63:0] old;
    logic [7:0] want_b;
    int n;
    want = 8'h80;
    last = 8'h00;
    n = 0;
    old = last_pat;
    @(posedge mclk);
    closed <= pat;
    scan_start <= 1'b1;
    for (int i = 0; i < 200 && scan_done !== 1'b1; i++) begin
      @(posedge mclk);
      scan_start <= poke && n == 3;
      #1;
      check("claim", claimed, col.onehot != 8'h00);
      if (col.onehot !== last && col.onehot !== 8'h00) begin
        check("column", col.onehot, want);
        want_b = ~want;
        check("low lines", col.onehot_b, want_b);
        check("address", col.addr, 7 - n);
        want = want >> 1;
        n++;
        if (n == 2) begin
          check("half", {cur_map[63:56], prev_map[63:56], cur_map[7:0]},
            {pat[63:56], old[63:56], old[7:0]});
        end
      end
      last = col.onehot;
    end
    check("columns", n, 8);
    check("done", scan_done, 1'b1);
    check("current", cur_map, pat);
    check("previous", prev_map, old);
    check("changed", chg_map, pat ^ old);
    repeat (2) @(posedge mclk);
    #1;
    check("idle", scan_busy, 1'b0);
    check("done drop", scan_done, 1'b0);
    last_pat = pat;
  endtask
  // Foreign traffic on the row port between scans
  task automatic idle_traffic;
    @(posedge mclk);
    idle_bus <= 8'hFF;
    repeat (20) @(posedge mclk);
    #1;
    check("idle claim", claimed, 1'b0);
    check("idle map", cur_map, last_pat);
    @(posedge mclk);
    idle_bus <= 8'h00;
  endtask
  // Bit-addressed reads along a diagonal
  task automatic read_bits(input logic [63:0] cur, input logic [63:0] prev);
    for (int i = 0; i < 64; i += 9) begin
      @(posedge mclk);
      bit_req.index <= i[5:0];
      repeat (2) @(posedge mclk);
      #1;
      check("bit", {bit_ans.cur, bit_ans.prev, bit_ans.rise, bit_ans.fall},
        {cur[i], prev[i], cur[i] & ~prev[i], ~cur[i] & prev[i]});
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    check("reset drive", col, {8'h00, 8'hFF, 3'h0});
    check("reset claim", claimed, 1'b0);
    check("reset busy", {scan_busy, scan_done}, 2'b00);
    check("reset current", cur_map, 64'h0);
    check("reset previous", prev_map, 64'h0);
    run_scan(64'hA5C3_0F01_8000_7E11, 1'b0);
    read_bits(64'hA5C3_0F01_8000_7E11, 64'h0);
    idle_traffic();
    run_scan(64'h5AC3_F000_0180_7E88, 1'b1);
    read_bits(64'h5AC3_F000_0180_7E88, 64'hA5C3_0F01_8000_7E11);
    run_scan(64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
    report_and_stop();
  end
endmodule // test_sensor_matrix_scanner
